// ==== src/pmx_pins.sv ====
// Port 3 alternate functions, expanded-bus pins, reset and loader entry
`timescale 1ns/1ps
`default_nettype none
`include "pmx_consts.svh"
// Behaviour
// - pin 3.0 is GPIO or UART receive
// - pin 3.1 is GPIO or UART transmit
// - pins 3.2, 3.3 are active-low interrupt inputs
// - pins 3.4, 3.5 feed timer count inputs
// - pin 3.6 strobes low on bus writes
// - pin 3.7 strobes low on bus reads
// - program-store enable low on external fetch
// - program-store pin normally driven, safe unconnected
// - program-store low in reset enters loader
// - reset input high puts device in reset
// - reset input pulled down internally
// - address latch enable pulses per bus cycle
// - port 0 multiplexes address and data, driven
// - port 2 drives high address byte
module pmx_pins #(
    parameter int ADDR_CYC = `PMX_ADDR_CYC,
    parameter int HOLD_CYC = `PMX_HOLD_CYC,
    parameter int STROBE_CYC = `PMX_STROBE_CYC
) (
    // Clock and system reset
    input wire logic clk,
    input wire logic rst_n,
    // Active-high reset pin
    input wire logic rst_pin_in,
    // Program-store enable pin, three signals
    input wire logic pgm_pin_in,
    output logic program_store_enable_n,
    output logic pgm_pin_oe,
    // Address latch enable pin
    output logic ale_pin,
    // Port 0 pins
    input wire logic [7:0] p0_pin_in,
    output logic [7:0] p0_pin_out,
    output logic [7:0] p0_pin_oe,
    // Port 2 pins
    output logic [7:0] p2_pin_out,
    output logic [7:0] p2_pin_oe,
    // Port 3 pins
    input wire logic [7:0] p3_pin_in,
    output logic [7:0] p3_pin_out,
    output logic [7:0] p3_pin_oe,
    // Port latches written by the core
    input wire logic [7:0] p0_latch,
    input wire logic [7:0] p2_latch,
    input wire logic [7:0] p3_latch,
    // Serial port hookup
    input wire logic uart_en,
    input wire logic uart_tx_pin,
    // Expanded-bus request from the core
    input wire logic bus_req,
    input wire pmx_pkg::pmx_kind_t bus_kind,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    output logic bus_busy,
    output logic bus_done,
    output logic [7:0] bus_rdata,
    // Pin levels seen by the core
    output logic [7:0] p0_read,
    output logic [7:0] p3_read,
    output logic uart_rx_pin,
    output logic ext_irq_zero_n,
    output logic ext_irq_one_n,
    output logic timer_zero_count_in,
    output logic timer_one_count_in,
    // Reset and loader state
    output logic dev_reset,
    output logic boot_loader_mode
);

    // Accept a bit once synchroniser stages two and three agree
    function automatic logic [7:0] pmx_agree(
        input logic [7:0] s2,
        input logic [7:0] s3,
        input logic [7:0] held
    );
        logic [7:0] same;
        same = ~(s2 ^ s3);
        pmx_agree = (same & s3) | (~same & held);
    endfunction

    // Carrier to the bus sequencer
    pmx_bus_if bus ();

    // Device reset as seen after the pin filter
    logic dev_rst;
    logic boot_mode;

    // Port 3 input synchroniser stages and accepted value
    logic [7:0] p3_s1_r;
    logic [7:0] p3_s2_r;
    logic [7:0] p3_s3_r;
    logic [7:0] p3_filt_r;

    // Port 0 input synchroniser stages and accepted value
    logic [7:0] p0_s1_r;
    logic [7:0] p0_s2_r;
    logic [7:0] p0_s3_r;
    logic [7:0] p0_filt_r;

    // Registered pin drives
    logic [7:0] p0_out_r;
    logic [7:0] p0_oe_r;
    logic [7:0] p2_out_r;
    logic [7:0] p2_oe_r;
    logic [7:0] p3_out_r;
    logic [7:0] p3_oe_r;
    logic pgm_out_r;
    logic pgm_oe_r;
    logic ale_r;

    // Registered bus status toward the core
    logic busy_r;
    logic done_r;

    // Next pin values
    logic [7:0] p0_eff;
    logic [7:0] p2_eff;
    logic [7:0] p3_eff;
    logic [7:0] p3_nxt;
    logic [7:0] p0_out_nxt;
    logic [7:0] p0_oe_nxt;
    logic [7:0] p2_out_nxt;
    logic [7:0] p2_oe_nxt;

    // Reset pin filter and loader entry capture
    pmx_rst_boot u_rst_boot (
        .clk(clk),
        .rst_n(rst_n),
        .rst_pin_in(rst_pin_in),
        .pgm_pin_in(pgm_pin_in),
        .dev_reset(dev_rst),
        .boot_mode(boot_mode)
    );

    // Expanded-bus cycle sequencer
    pmx_bus_seq #(
        .ADDR_CYC(ADDR_CYC),
        .HOLD_CYC(HOLD_CYC),
        .STROBE_CYC(STROBE_CYC)
    ) u_bus_seq (
        .clk(clk),
        .rst_n(rst_n),
        .bus(bus)
    );

    // Requests are dropped while the device sits in reset
    assign bus.req = bus_req & ~dev_rst;
    assign bus.kind = bus_kind;
    assign bus.addr = bus_addr;
    assign bus.wdata = bus_wdata;
    assign bus.halt = dev_rst;
    assign bus.p0_in = p0_filt_r;

    // Port 3 synchroniser; stage one feeds only stage two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p3_s1_r <= `PMX_PORT_RST;
            p3_s2_r <= `PMX_PORT_RST;
            p3_s3_r <= `PMX_PORT_RST;
        end else begin
            p3_s1_r <= p3_pin_in;
            p3_s2_r <= p3_s1_r;
            p3_s3_r <= p3_s2_r;
        end
    end

    // Port 3 accepted levels; a one-cycle glitch never gets through
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p3_filt_r <= `PMX_PORT_RST;
        end else begin
            p3_filt_r <= pmx_agree(p3_s2_r, p3_s3_r, p3_filt_r);
        end
    end

    // Port 0 synchroniser, also the read data path of the bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p0_s1_r <= `PMX_PORT_RST;
            p0_s2_r <= `PMX_PORT_RST;
            p0_s3_r <= `PMX_PORT_RST;
            p0_filt_r <= `PMX_PORT_RST;
        end else begin
            p0_s1_r <= p0_pin_in;
            p0_s2_r <= p0_s1_r;
            p0_s3_r <= p0_s2_r;
            p0_filt_r <= pmx_agree(p0_s2_r, p0_s3_r, p0_filt_r);
        end
    end

    // Port 3 drive: latch ANDed with any alternate output
    always_comb begin
        // In device reset the latches read as all ones, so every pin floats except pin 3.1 while the transmitter drives it low
        p3_eff = dev_rst ? `PMX_PORT_RST : p3_latch;
        p3_nxt = p3_eff;
        if (uart_en) begin
            // Latch bit must be one for the transmitter to show
            p3_nxt[`PMX_BIT_UTX] = p3_eff[`PMX_BIT_UTX] & uart_tx_pin;
        end
        p3_nxt[`PMX_BIT_WSTB] = p3_eff[`PMX_BIT_WSTB] & bus.wr_n;
        p3_nxt[`PMX_BIT_RSTB] = p3_eff[`PMX_BIT_RSTB] & bus.rd_n;
    end

    // Port 0 and port 2 drive: bus owns them during a cycle
    always_comb begin
        p0_eff = dev_rst ? `PMX_PORT_RST : p0_latch;
        p2_eff = dev_rst ? `PMX_PORT_RST : p2_latch;
        if (bus.active) begin
            // Full drive both ways, so no pull-ups are needed here
            p0_out_nxt = bus.p0_out;
            p0_oe_nxt = {8{bus.p0_oe}};
            p2_out_nxt = bus.p2_out;
            p2_oe_nxt = 8'hff;
        end else begin
            // Port 0 as GPIO is open-drain and can only pull low
            p0_out_nxt = 8'h00;
            p0_oe_nxt = ~p0_eff;
            p2_out_nxt = p2_eff;
            p2_oe_nxt = ~p2_eff;
        end
    end

    // Port 3 pin registers; a one is left to the pin's pull-up
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p3_out_r <= `PMX_PORT_RST;
            p3_oe_r <= 8'h00;
        end else begin
            p3_out_r <= p3_nxt;
            p3_oe_r <= ~p3_nxt;
        end
    end

    // Port 0 and port 2 pin registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            p0_out_r <= 8'h00;
            p0_oe_r <= 8'h00;
            p2_out_r <= `PMX_PORT_RST;
            p2_oe_r <= 8'h00;
        end else begin
            p0_out_r <= p0_out_nxt;
            p0_oe_r <= p0_oe_nxt;
            p2_out_r <= p2_out_nxt;
            p2_oe_r <= p2_oe_nxt;
        end
    end

    // Latch enable pin, high only in the address phase
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ale_r <= 1'b0;
        end else begin
            ale_r <= bus.ale;
        end
    end

    // Program-store pin: driven in run, released in reset
    // Releasing it in reset lets an open-drain pull-down be seen cleanly
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pgm_out_r <= 1'b1;
            pgm_oe_r <= 1'b0;
        end else begin
            pgm_out_r <= bus.pgm_n;
            pgm_oe_r <= ~dev_rst;
        end
    end

    // Bus status toward the core, one cycle behind the sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            busy_r <= bus.busy;
            done_r <= bus.done & ~dev_rst;
        end
    end

    // Pin outputs
    assign p3_pin_out = p3_out_r;
    assign p3_pin_oe = p3_oe_r;
    assign p0_pin_out = p0_out_r;
    assign p0_pin_oe = p0_oe_r;
    assign p2_pin_out = p2_out_r;
    assign p2_pin_oe = p2_oe_r;
    assign ale_pin = ale_r;
    assign program_store_enable_n = pgm_out_r;
    assign pgm_pin_oe = pgm_oe_r;

    // Core-side outputs
    assign bus_busy = busy_r;
    assign bus_done = done_r;
    assign bus_rdata = bus.rdata;
    assign p0_read = p0_filt_r;
    assign p3_read = p3_filt_r;
    assign uart_rx_pin = p3_filt_r[`PMX_BIT_URX];
    assign ext_irq_zero_n = p3_filt_r[`PMX_BIT_IRQ0];
    assign ext_irq_one_n = p3_filt_r[`PMX_BIT_IRQ1];
    assign timer_zero_count_in = p3_filt_r[`PMX_BIT_TMR0];
    assign timer_one_count_in = p3_filt_r[`PMX_BIT_TMR1];
    assign dev_reset = dev_rst;
    assign boot_loader_mode = boot_mode;
endmodule
`default_nettype wire

// ==== pkg/pmx_consts.svh ====
// Timing counts, port reset values and port 3 bit positions for the pin block
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH
`define PMX_CLK_HZ 10000000
`define PMX_ADDR_NS 200
`define PMX_HOLD_NS 100
`define PMX_STROBE_NS 600
`define PMX_ADDR_CYC ((`PMX_ADDR_NS * (`PMX_CLK_HZ / 1000000) + 999) / 1000)
`define PMX_HOLD_CYC ((`PMX_HOLD_NS * (`PMX_CLK_HZ / 1000000) + 999) / 1000)
`define PMX_STROBE_CYC ((`PMX_STROBE_NS * (`PMX_CLK_HZ / 1000000) + 999) / 1000)
`define PMX_PORT_RST 8'hff
`define PMX_BIT_URX 0
`define PMX_BIT_UTX 1
`define PMX_BIT_IRQ0 2
`define PMX_BIT_IRQ1 3
`define PMX_BIT_TMR0 4
`define PMX_BIT_TMR1 5
`define PMX_BIT_WSTB 6
`define PMX_BIT_RSTB 7
`endif

// ==== pkg/pmx_pkg.sv ====
// Types shared by the port 3 and expanded-bus pin block
`default_nettype none
package pmx_pkg;
    // Kind of expanded-bus cycle the core asks for
    typedef enum logic [1:0] {PMX_K_FETCH, PMX_K_READ, PMX_K_WRITE} pmx_kind_t;
    // Phases of one expanded-bus cycle
    typedef enum logic [2:0] {
        PMX_S_IDLE, PMX_S_ADDR, PMX_S_HOLD, PMX_S_STROBE, PMX_S_END
    } pmx_seq_t;
endpackage
`default_nettype wire

// ==== pkg/pmx_bus_if.sv ====
// Carrier between the pin top and the expanded-bus sequencer
`timescale 1ns/1ps
`default_nettype none
interface pmx_bus_if;
    logic req;
    pmx_pkg::pmx_kind_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic halt;
    logic [7:0] p0_in;
    logic busy;
    logic done;
    logic [7:0] rdata;
    logic ale;
    logic wr_n;
    logic rd_n;
    logic pgm_n;
    logic active;
    logic [7:0] p0_out;
    logic p0_oe;
    logic [7:0] p2_out;
    modport seq (
        input req, kind, addr, wdata, halt, p0_in,
        output busy, done, rdata, ale, wr_n, rd_n, pgm_n, active, p0_out, p0_oe, p2_out
    );
    modport top (
        output req, kind, addr, wdata, halt, p0_in,
        input busy, done, rdata, ale, wr_n, rd_n, pgm_n, active, p0_out, p0_oe, p2_out
    );
endinterface
`default_nettype wire

// ==== src/pmx_bus_seq.sv ====
// Expanded-bus cycle sequencer: address phase with latch pulse, hold, strobe, end
`timescale 1ns/1ps
`default_nettype none
`include "pmx_consts.svh"
module pmx_bus_seq #(
    parameter int ADDR_CYC = `PMX_ADDR_CYC,
    parameter int HOLD_CYC = `PMX_HOLD_CYC,
    parameter int STROBE_CYC = `PMX_STROBE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    pmx_bus_if.seq bus
);
    pmx_pkg::pmx_seq_t state_r; // Current phase
    logic [3:0] cnt_r; // Cycles left in the phase
    pmx_pkg::pmx_kind_t kind_r; // Cycle kind taken with the request
    logic [15:0] addr_r; // Address held for the whole cycle
    logic [7:0] wdata_r; // Write byte held for the whole cycle
    logic [7:0] rdata_r; // Byte caught at the end of a read or fetch strobe
    logic last;
    logic in_addr;
    logic in_strobe;
    logic is_wr;

    assign last = (cnt_r == 4'h0);
    assign in_addr = (state_r == pmx_pkg::PMX_S_ADDR) || (state_r == pmx_pkg::PMX_S_HOLD);
    assign in_strobe = (state_r == pmx_pkg::PMX_S_STROBE);
    assign is_wr = (kind_r == pmx_pkg::PMX_K_WRITE);

    // Phase sequencing; a device reset aborts any cycle in flight
    always_ff @(posedge clk) begin
        if (!rst_n || bus.halt) begin
            state_r <= pmx_pkg::PMX_S_IDLE;
            cnt_r <= 4'h0;
        end else begin
            case (state_r)
                pmx_pkg::PMX_S_IDLE: begin
                    if (bus.req) begin
                        state_r <= pmx_pkg::PMX_S_ADDR;
                        cnt_r <= 4'(ADDR_CYC - 1);
                    end
                end
                pmx_pkg::PMX_S_ADDR: begin
                    if (last) begin
                        state_r <= pmx_pkg::PMX_S_HOLD;
                        cnt_r <= 4'(HOLD_CYC - 1);
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                pmx_pkg::PMX_S_HOLD: begin
                    if (last) begin
                        state_r <= pmx_pkg::PMX_S_STROBE;
                        cnt_r <= 4'(STROBE_CYC - 1);
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                pmx_pkg::PMX_S_STROBE: begin
                    if (last) begin
                        state_r <= pmx_pkg::PMX_S_END;
                    end else begin
                        cnt_r <= cnt_r - 4'h1;
                    end
                end
                default: begin
                    state_r <= pmx_pkg::PMX_S_IDLE;
                end
            endcase
        end
    end

    // Request capture; only taken while idle, so the cycle sees stable values
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            kind_r <= pmx_pkg::PMX_K_FETCH;
            addr_r <= 16'h0000;
            wdata_r <= 8'h00;
        end else if (state_r == pmx_pkg::PMX_S_IDLE && bus.req && !bus.halt) begin
            kind_r <= bus.kind;
            addr_r <= bus.addr;
            wdata_r <= bus.wdata;
        end
    end

    // Read data is caught on the last strobe cycle, before the strobe rises
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (in_strobe && last && !is_wr) begin
            rdata_r <= bus.p0_in;
        end
    end

    assign bus.busy = (state_r != pmx_pkg::PMX_S_IDLE);
    assign bus.active = (state_r != pmx_pkg::PMX_S_IDLE);
    assign bus.done = (state_r == pmx_pkg::PMX_S_END);
    assign bus.rdata = rdata_r;
    assign bus.ale = (state_r == pmx_pkg::PMX_S_ADDR);
    assign bus.wr_n = !(in_strobe && is_wr);
    assign bus.rd_n = !(in_strobe && kind_r == pmx_pkg::PMX_K_READ);
    assign bus.pgm_n = !(in_strobe && kind_r == pmx_pkg::PMX_K_FETCH);
    // Low address first, then write data held one cycle past the strobe
    assign bus.p0_oe = in_addr || (is_wr && (in_strobe || state_r == pmx_pkg::PMX_S_END));
    assign bus.p0_out = in_addr ? addr_r[7:0] : wdata_r;
    assign bus.p2_out = addr_r[15:8];
endmodule
`default_nettype wire

// ==== src/pmx_rst_boot.sv ====
// Reset pin and bootstrap-loader entry capture
`timescale 1ns/1ps
`default_nettype none
module pmx_rst_boot (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rst_pin_in,
    input wire logic pgm_pin_in,
    output logic dev_reset,
    output logic boot_mode
);
    logic [2:0] rst_sync_r; // Reset pin synchroniser, bit 0 first
    logic [2:0] pgm_sync_r; // Program-store pin synchroniser, bit 0 first
    logic rst_filt_r; // Accepted reset pin level
    logic pgm_filt_r; // Accepted program-store pin level
    logic boot_r; // Loader entry decision

    // Three-stage synchronisers; power-on holds the device in reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_sync_r <= 3'b111;
            pgm_sync_r <= 3'b111;
        end else begin
            rst_sync_r <= {rst_sync_r[1:0], rst_pin_in};
            pgm_sync_r <= {pgm_sync_r[1:0], pgm_pin_in};
        end
    end

    // A level counts only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_filt_r <= 1'b1;
            pgm_filt_r <= 1'b1;
        end else begin
            if (rst_sync_r[1] == rst_sync_r[2]) begin
                rst_filt_r <= rst_sync_r[2];
            end
            if (pgm_sync_r[1] == pgm_sync_r[2]) begin
                pgm_filt_r <= pgm_sync_r[2];
            end
        end
    end

    // Track the pin while in reset; the last value stands after release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            boot_r <= 1'b0;
        end else if (rst_filt_r) begin
            boot_r <= ~pgm_filt_r;
        end
    end

    assign dev_reset = rst_filt_r;
    assign boot_mode = boot_r;
endmodule
`default_nettype wire

// ==== tb/pmx_pins_checker.sv ====
// Concurrent checks on the ports of the pin block
`timescale 1ns/1ps
`default_nettype none
module pmx_pins_checker #(
    parameter int ADDR_CYC = 2,
    parameter int HOLD_CYC = 1,
    parameter int STROBE_CYC = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rst_pin_in,
    input wire logic pgm_pin_oe,
    input wire logic program_store_enable_n,
    input wire logic ale_pin,
    input wire logic [7:0] p0_pin_out,
    input wire logic [7:0] p0_pin_oe,
    input wire logic [7:0] p2_pin_out,
    input wire logic [7:0] p2_pin_oe,
    input wire logic [7:0] p3_pin_out,
    input wire logic [7:0] p3_latch,
    input wire logic uart_en,
    input wire logic uart_tx_pin,
    input wire pmx_pkg::pmx_kind_t bus_kind,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_busy,
    input wire logic bus_done,
    input wire logic dev_reset,
    input wire logic boot_loader_mode
);
    // Latch enable rise to the done pulse spans all three phases
    localparam int DONE_DLY = ADDR_CYC + HOLD_CYC + STROBE_CYC;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Two cycles of latch enable, then the hold cycle
    sequence addr_phase;
        ale_pin ##1 ale_pin ##1 !ale_pin;
    endsequence
    // Strobe low for the whole strobe phase, high again at the end
    sequence strobe_low(s);
        addr_phase ##1 (!s) [*6] ##1 s;
    endsequence
    wr_strobe_a: assert property (
        $rose(ale_pin) && bus_kind == pmx_pkg::PMX_K_WRITE |-> strobe_low(p3_pin_out[6]))
        else $error("write strobe sequence wrong");
    rd_strobe_a: assert property (
        $rose(ale_pin) && bus_kind == pmx_pkg::PMX_K_READ |-> strobe_low(p3_pin_out[7]))
        else $error("read strobe sequence wrong");
    fetch_strobe_a: assert property (
        $rose(ale_pin) && bus_kind == pmx_pkg::PMX_K_FETCH |-> strobe_low(program_store_enable_n))
        else $error("fetch strobe sequence wrong");
    done_time_a: assert property (
        $rose(ale_pin) |-> bus_busy ##DONE_DLY (bus_done && bus_busy) ##1 !bus_busy)
        else $error("done pulse out of place");
    addr_hi_a: assert property (ale_pin |-> p2_pin_out == bus_addr[15:8] && p2_pin_oe == 8'hff)
        else $error("high address not on port 2");
    addr_lo_a: assert property (ale_pin |-> p0_pin_out == bus_addr[7:0] && p0_pin_oe == 8'hff)
        else $error("low address not on port 0");
    wr_data_a: assert property (
        bus_busy && !p3_pin_out[6] |-> p0_pin_out == bus_wdata && p0_pin_oe == 8'hff)
        else $error("write data not driven");
    rst_in_a: assert property (rst_pin_in [*4] |=> dev_reset)
        else $error("reset pin ignored");
    rst_out_a: assert property (!rst_pin_in [*6] |=> !dev_reset)
        else $error("device stuck in reset");
    pgm_free_a: assert property (dev_reset ##1 dev_reset |-> !pgm_pin_oe)
        else $error("program store pin driven in reset");
    pgm_drive_a: assert property (!dev_reset ##1 !dev_reset |-> pgm_pin_oe)
        else $error("program store pin not driven");
    boot_hold_a: assert property (
        !dev_reset && !$past(dev_reset) |-> $stable(boot_loader_mode))
        else $error("loader flag changed while running");
    uart_out_a: assert property (
        !dev_reset && uart_en && p3_latch[1] ##1 !dev_reset |-> p3_pin_out[1] == $past(uart_tx_pin))
        else $error("transmit bit not on pin 1");
endmodule
bind pmx_pins pmx_pins_checker #(
    .ADDR_CYC(ADDR_CYC), .HOLD_CYC(HOLD_CYC), .STROBE_CYC(STROBE_CYC)
) u_chk (.*);
`default_nettype wire

// ==== tb/pmx_ext_mem.sv ====
// External address latch and memory on the expanded bus
`timescale 1ns/1ps
`default_nettype none
module pmx_ext_mem (
    input wire logic clk,
    input wire logic ale_pin,
    input wire logic [7:0] p0_w,
    input wire logic [7:0] p2_w,
    input wire logic wr_w,
    input wire logic rd_w,
    input wire logic pgm_w,
    output logic [7:0] mem_d,
    output logic mem_oe,
    output logic [15:0] wr_addr,
    output logic [7:0] wr_data
);
    logic [7:0] lat_lo = 8'h00; // Low address held by the latch
    // Latch follows port 0 while the enable is high
    always @(posedge clk) begin
        if (ale_pin) begin
            lat_lo <= p0_w;
        end
    end
    // Byte depends on both address bytes
    assign mem_d = lat_lo ^ p2_w ^ 8'h3c;
    // Drives only under a read or fetch strobe
    assign mem_oe = !rd_w || !pgm_w;
    // Write taken while the strobe is low
    always @(posedge clk) begin
        if (!wr_w) begin
            wr_data <= p0_w;
            wr_addr <= {p2_w, lat_lo};
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the port 3 and expanded-bus pin block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rst_pin_in = 1'b0; // Zero stands for a floating pin with its pull-down
    logic pgm_pull = 1'b0; // Open-drain loader pull
    logic [7:0] ext_p3 = 8'hff; // Far-side port 3 levels, pulled up when idle
    logic [7:0] p3_latch = 8'hff;
    logic uart_en = 1'b0;
    logic uart_tx_pin = 1'b1;
    logic bus_req = 1'b0;
    pmx_pkg::pmx_kind_t bus_kind = pmx_pkg::PMX_K_FETCH;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00;
    logic pgm_pin_in, program_store_enable_n, pgm_pin_oe, ale_pin, bus_busy, bus_done;
    logic uart_rx_pin, ext_irq_zero_n, ext_irq_one_n, timer_zero_count_in, timer_one_count_in;
    logic dev_reset, boot_loader_mode, mem_oe;
    logic [7:0] p0_pin_in, p0_pin_out, p0_pin_oe, p2_pin_out, p2_pin_oe, p2_w;
    logic [7:0] p3_pin_in, p3_pin_out, p3_pin_oe, bus_rdata, p0_read, p3_read, mem_d, wr_data;
    logic [15:0] wr_addr;
    int mismatches = 0;
    int num_checks = 0;
    always #50 clk = ~clk;
    // Wire levels: the driver wins, else the far side, else the pull-up
    assign p0_pin_in = (p0_pin_oe & p0_pin_out) | (~p0_pin_oe & (mem_oe ? mem_d : 8'hff));
    assign p2_w = (p2_pin_oe & p2_pin_out) | ~p2_pin_oe;
    assign p3_pin_in = (p3_pin_oe & p3_pin_out) | (~p3_pin_oe & ext_p3);
    // Open-drain pull forces low only
    assign pgm_pin_in = (pgm_pin_oe ? program_store_enable_n : 1'b1) & !pgm_pull;
    pmx_pins dut (.p0_latch(8'hff), .p2_latch(8'hff), .*);
    pmx_ext_mem mem (.clk, .ale_pin, .p0_w(p0_pin_in), .p2_w, .wr_w(p3_pin_in[6]),
        .rd_w(p3_pin_in[7]), .pgm_w(pgm_pin_in), .mem_d, .mem_oe, .wr_addr, .wr_data);
    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Inputs always change 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bounded wait for the device reset state
    task automatic wait_reset(input logic v);
        int i;
        for (i = 0; i < 40 && dev_reset !== v; i++) begin
            step(1);
        end
        if (dev_reset !== v) begin
            check(dev_reset, v, "device reset timeout");
            close_out();
        end
    endtask
    // One bus cycle; request held until done so cycles can run back to back
    task automatic bus_cycle(input pmx_pkg::pmx_kind_t k, input logic [15:0] a,
        input logic [7:0] d);
        int i;
        bus_req = 1'b1;
        bus_kind = k;
        bus_addr = a;
        bus_wdata = d;
        step(1);
        for (i = 0; i < 30 && bus_done !== 1'b1; i++) begin
            step(1);
        end
        if (bus_done !== 1'b1) begin
            check(bus_done, 1'b1, "bus done timeout");
            close_out();
        end else if (k == pmx_pkg::PMX_K_WRITE) begin
            check(wr_data, d, "written byte");
            check(wr_addr, a, "written address");
        end else begin
            check(bus_rdata, a[7:0] ^ a[15:8] ^ 8'h3c, "read byte");
        end
    endtask
    // Floating reset pin lets the device start normally
    task automatic t_start();
        wait_reset(1'b0);
        check(boot_loader_mode, 1'b0, "no loader at start");
        step(2);
        check(pgm_pin_oe, 1'b1, "program store driven");
    endtask
    // All three cycle kinds back to back
    task automatic t_bus();
        bus_cycle(pmx_pkg::PMX_K_WRITE, 16'h12c4, 8'h9e);
        bus_cycle(pmx_pkg::PMX_K_READ, 16'hff00, 8'h00);
        bus_cycle(pmx_pkg::PMX_K_FETCH, 16'h00f0, 8'h00);
        bus_req = 1'b0;
        step(5);
        check({p2_pin_oe, p0_read}, 16'h00ff, "bus pins released");
    endtask
    // Alternate inputs, plain outputs and the transmit pin
    task automatic t_port3();
        logic [7:0] pat [2] = '{8'ha5, 8'h5a};
        foreach (pat[j]) begin
            ext_p3 = pat[j];
            step(6);
            check(p3_read, pat[j], "port 3 levels");
            check(uart_rx_pin, pat[j][0], "receive input");
            check({ext_irq_one_n, ext_irq_zero_n}, pat[j][3:2], "interrupt inputs");
            check({timer_one_count_in, timer_zero_count_in}, pat[j][5:4], "timer inputs");
        end
        ext_p3 = 8'hff;
        p3_latch = 8'hf0;
        step(6);
        check({p3_pin_oe, p3_pin_out}, 16'h0ff0, "port 3 driven low");
        check(p3_read, 8'hf0, "port 3 readback");
        p3_latch = 8'hff;
        uart_en = 1'b1;
        uart_tx_pin = 1'b0;
        step(2);
        check(p3_pin_out[1], 1'b0, "transmit low");
        uart_tx_pin = 1'b1;
        step(2);
        check(p3_pin_out[1], 1'b1, "transmit high");
        uart_en = 1'b0;
        uart_tx_pin = 1'b0;
        step(2);
        check(p3_pin_out[1], 1'b1, "pin 1 back to latch");
    endtask
    // Loader entry, a late pull, then a plain reset
    task automatic t_boot();
        rst_pin_in = 1'b1;
        wait_reset(1'b1);
        step(2);
        check(pgm_pin_oe, 1'b0, "program store released");
        pgm_pull = 1'b1;
        step(10);
        check(boot_loader_mode, 1'b1, "loader entry");
        rst_pin_in = 1'b0;
        wait_reset(1'b0);
        step(4);
        pgm_pull = 1'b0;
        check(boot_loader_mode, 1'b1, "loader kept");
        step(2);
        pgm_pull = 1'b1;
        step(10);
        check(boot_loader_mode, 1'b1, "late pull ignored");
        pgm_pull = 1'b0;
        rst_pin_in = 1'b1;
        wait_reset(1'b1);
        step(6);
        rst_pin_in = 1'b0;
        wait_reset(1'b0);
        step(2);
        check(boot_loader_mode, 1'b0, "normal start");
    endtask
    initial begin
        step(5);
        rst_n = 1'b1;
        t_start();
        t_bus();
        t_port3();
        t_boot();
        close_out();
    end
endmodule
`default_nettype wire
